// ### hdl/bfd_decoder.sv
// byte-oriented file register instruction decoder and executor
// Notes on behaviour
// - each file instruction reads its register, operates, and stores the result where chosen.
// - the file read happens even when the instruction only writes the register.
// - clearing the second I/O port reads it first, and that read clears its change mismatch.
// - the seven-bit address field picks one of 128 file locations, 0x00 to 0x7F.
// - the bit index field picks one bit of an 8-bit register for bit operations.
// - don't-care bits are ignored; either value behaves the same.
// - destination bit 0 stores to the accumulator, 1 stores back to the file register.
// - nibble 0001 clears the file (bit 7 set, after reading) or the accumulator, and sets zero.
// - nibble 0100 ORs accumulator with file, stores per destination, updates only zero.
// - nibble 1011 decrements, stores, skips on zero, takes 1 or 2 cycles, touches no flags.
// - nibble 1111 increments, stores, skips on zero, takes 1 or 2 cycles, touches no flags.
// - each instruction cycle is four clock periods and most instructions finish in one.
// - a taken skip spends the next instruction cycle as a no-operation.
//
// Chosen here: the register offsets and the APB slave port.
module bfd_decoder (
   input  wire logic              CLK_I,
   input  wire logic              RST_N_I,
   input  wire logic              PSEL_I,
   input  wire logic              PENABLE_I,
   input  wire logic              PWRITE_I,
   input  wire logic [11:0]       PADDR_I,
   input  wire logic [31:0]       PWDATA_I,
   output logic      [31:0]       PRDATA_O,
   output logic                   PREADY_O,
   output logic                   PSLVERR_O,
   input  wire logic [13:0]       INSTR_I,
   input  wire logic              INSTR_VLD_I,
   output logic                   INSTR_TAKE_O,
   output logic                   SKIP_O,
   output logic      [6:0]        FILE_ADDR_O,
   output logic                   FILE_RD_O,
   input  wire logic [7:0]        FILE_RDATA_I,
   output logic                   FILE_WR_O,
   output logic      [7:0]        FILE_WDATA_O,
   output logic                   PORT_CHG_CLR_O
);
   import bfd_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   // the whole block state lives in one packed struct
   bfd_state_t s_q;
   bfd_state_t s_d;

   // ---------------------------------------------------------------
   // decode of the latched word
   // ---------------------------------------------------------------
   // fields of the word latched at the end of Q1
   logic [1:0] cls;
   logic [3:0] op;
   logic       dst;
   logic [6:0] fa;
   logic [2:0] bidx;
   logic [1:0] bop;
   logic       is_byte;
   logic       is_bit;
   logic       known;
   logic       reads_file;

   // don't-care bits are never looked at, so either value acts alike
   assign cls     = s_q.instr[CLS_HI:CLS_LO];
   assign op      = s_q.instr[OP_HI:OP_LO];
   assign dst     = s_q.instr[DST_BIT];
   assign fa      = s_q.instr[FA_HI:0];
   assign bidx    = s_q.instr[BIT_HI:BIT_LO];
   assign bop     = s_q.instr[BOP_HI:BOP_LO];
   assign is_byte = (cls == CLS_BYTE);
   assign is_bit  = (cls == CLS_BIT) && (bop == BOP_CLR || bop == BOP_SET);

   // opcodes this block executes; the rest are left to other logic
   always_comb begin
      known = 1'b0;
      if (is_bit) begin
         known = 1'b1;
      end else if (is_byte) begin
         case (op)
            OP_CLR, OP_DEC, OP_IOR, OP_AND, OP_ADD,
            OP_MOV, OP_COM, OP_INC, OP_DSZ, OP_ISZ: known = 1'b1;
            default: known = 1'b0;
         endcase
      end
   end

   // every file-naming op reads, even clear; only the accumulator clear has no file
   assign reads_file = known && !(is_byte && op == OP_CLR && !dst);

   // ---------------------------------------------------------------
   // operation unit
   // ---------------------------------------------------------------
   // operand, result and flag-update controls
   logic [7:0] fv;
   logic [7:0] res;
   logic [8:0] sum;
   logic [4:0] lsum;
   logic       to_file;
   logic       upd_z;
   logic       upd_cd;
   logic       skip_op;

   // the file value is used in the cycle its read strobe is high
   // limitation: the register file must answer combinationally from the address
   assign fv   = FILE_RDATA_I;
   assign sum  = {1'b0, s_q.acc} + {1'b0, fv};
   assign lsum = {1'b0, s_q.acc[3:0]} + {1'b0, fv[3:0]};

   // pass-through by default, which is all a move needs
   always_comb begin
      res     = fv;
      to_file = dst;
      upd_z   = 1'b1;
      upd_cd  = 1'b0;
      skip_op = 1'b0;
      if (is_bit) begin
         to_file = 1'b1;
         upd_z   = 1'b0;
         res[bidx] = (bop == BOP_SET);
      end else begin
         case (op)
            OP_CLR: res = 8'h00;
            OP_IOR: res = s_q.acc | fv;
            OP_AND: res = s_q.acc & fv;
            OP_ADD: begin
               res    = sum[7:0];
               upd_cd = 1'b1;
            end
            OP_COM: res = ~fv;
            OP_DEC: res = fv - 8'h01;
            OP_INC: res = fv + 8'h01;
            OP_MOV: res = fv;
            OP_DSZ: begin
               res     = fv - 8'h01;
               upd_z   = 1'b0;
               skip_op = (res == 8'h00);
            end
            OP_ISZ: begin
               res     = fv + 8'h01;
               upd_z   = 1'b0;
               skip_op = (res == 8'h00);
            end
            default: res = fv;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // apb decode
   // ---------------------------------------------------------------
   // bus side: access phase, write strobe and read mux
   logic        acc_ph;
   logic        wr_en;
   logic        hit;
   logic [31:0] rdata;

   assign acc_ph = PSEL_I && PENABLE_I;
   // writes land on the edge where the registered ready is seen high
   assign wr_en  = acc_ph && s_q.pready && PWRITE_I;

   // read mux; an unmapped offset answers zero with a slave error
   always_comb begin
      hit   = 1'b1;
      rdata = 32'h0000_0000;
      case (PADDR_I)
         CTRL_OFS:   rdata[0] = s_q.run;
         ACC_OFS:    rdata[7:0] = s_q.acc;
         STATUS_OFS: begin
            rdata[ST_C]  = s_q.c;
            rdata[ST_DC] = s_q.dc;
            rdata[ST_Z]  = s_q.z;
            rdata[ST_FO] = s_q.foreign;
         end
         INSTR_OFS:  rdata[IW-1:0] = s_q.instr;
         default:    hit = 1'b0;
      endcase
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   // strobes default low so each one is a single-cycle pulse
   always_comb begin
      s_d          = s_q;
      s_d.frd      = 1'b0;
      s_d.fwr      = 1'b0;
      s_d.port_clr = 1'b0;
      s_d.take     = 1'b0;
      s_d.skip     = 1'b0;

      // software writes first; the instruction path below overrides them
      if (wr_en && PADDR_I == CTRL_OFS) begin
         s_d.run = PWDATA_I[0];
      end
      if (wr_en && PADDR_I == ACC_OFS) begin
         s_d.acc = PWDATA_I[7:0];
      end
      if (wr_en && PADDR_I == STATUS_OFS) begin
         s_d.c  = PWDATA_I[ST_C];
         s_d.dc = PWDATA_I[ST_DC];
         s_d.z  = PWDATA_I[ST_Z];
         if (PWDATA_I[ST_FO]) begin
            s_d.foreign = 1'b0;                                // write one to clear
         end
      end

      // four clock phases make one instruction cycle
      case (s_q.ph)
         // Q1: take a word if the core runs and one is offered
         PH_Q1: begin
            s_d.ph     = PH_Q2;
            s_d.op_vld = 1'b0;
            if (s_q.run && INSTR_VLD_I) begin
               s_d.take  = 1'b1;
               s_d.instr = INSTR_I;
               // a pending skip consumes this word as a no-operation
               s_d.op_vld    = !s_q.skip_pend;
               s_d.skip_pend = 1'b0;
            end
         end
         // Q2: address the file; every file-naming op reads here
         PH_Q2: begin
            s_d.ph = PH_Q3;
            if (s_q.op_vld && reads_file) begin
               s_d.faddr    = fa;
               s_d.frd      = 1'b1;
               s_d.port_clr = (fa == SECOND_IO_PORT_ADDR);
            end
            if (s_q.op_vld && !known) begin
               s_d.foreign = 1'b1;                             // set beats clear
            end
         end
         // Q3: the result goes to the accumulator or out as a file write
         PH_Q3: begin
            s_d.ph = PH_Q4;
            if (s_q.op_vld && known) begin
               if (to_file) begin
                  s_d.fwr    = 1'b1;
                  s_d.fwdata = res;
               end else begin
                  s_d.acc = res;
               end
               if (upd_z) begin
                  s_d.z = (res == 8'h00);
               end
               if (upd_cd) begin
                  s_d.c  = sum[8];
                  s_d.dc = lsum[4];
               end
               if (skip_op) begin
                  s_d.skip      = 1'b1;
                  s_d.skip_pend = 1'b1;
               end
            end
         end
         // Q4: the file takes the write strobe; nothing else to do
         PH_Q4: s_d.ph = PH_Q1;
         default: s_d.ph = PH_Q1;
      endcase

      // one wait state, then ready; data and error held with it
      if (acc_ph && !s_q.pready) begin
         s_d.pready  = 1'b1;
         s_d.prdata  = PWRITE_I ? 32'h0000_0000 : rdata;
         s_d.pslverr = !hit;
      end else begin
         s_d.pready  = 1'b0;
         s_d.pslverr = 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   // async clear restarts the phase counter at Q1 with the core stopped
   // only constants load here, so reset needs no clock
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         s_q <= '0;
         s_q.ph  <= PH_Q1;
         s_q.acc <= ACC_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs straight from state
   // ---------------------------------------------------------------
   // no gates here, so every pin is a flop output
   assign PRDATA_O       = s_q.prdata;
   assign PREADY_O       = s_q.pready;
   assign PSLVERR_O      = s_q.pslverr;
   assign INSTR_TAKE_O   = s_q.take;
   assign SKIP_O         = s_q.skip;
   assign FILE_ADDR_O    = s_q.faddr;
   assign FILE_RD_O      = s_q.frd;
   assign FILE_WR_O      = s_q.fwr;
   assign FILE_WDATA_O   = s_q.fwdata;
   assign PORT_CHG_CLR_O = s_q.port_clr;

endmodule : bfd_decoder

// ### hdl/bfd_pkg.sv
// constants, encodings and state type of the byte file op decoder
package bfd_pkg;
   // ---------------------------------------------------------------
   // instruction fields
   // ---------------------------------------------------------------
   localparam int IW       = 14;
   localparam int CLS_HI   = 13;
   localparam int CLS_LO   = 12;
   localparam int OP_HI    = 11;
   localparam int OP_LO    = 8;
   localparam int DST_BIT  = 7;
   localparam int FA_HI    = 6;
   localparam int BIT_HI   = 9;
   localparam int BIT_LO   = 7;
   localparam int BOP_HI   = 11;
   localparam int BOP_LO   = 10;
   localparam logic [1:0] CLS_BYTE = 2'h0;
   localparam logic [1:0] CLS_BIT  = 2'h1;
   // byte op nibbles
   localparam logic [3:0] OP_CLR = 4'h1;
   localparam logic [3:0] OP_DEC = 4'h3;
   localparam logic [3:0] OP_IOR = 4'h4;
   localparam logic [3:0] OP_AND = 4'h5;
   localparam logic [3:0] OP_ADD = 4'h7;
   localparam logic [3:0] OP_MOV = 4'h8;
   localparam logic [3:0] OP_COM = 4'h9;
   localparam logic [3:0] OP_INC = 4'hA;
   localparam logic [3:0] OP_DSZ = 4'hB;
   localparam logic [3:0] OP_ISZ = 4'hF;
   // bit op selects
   localparam logic [1:0] BOP_CLR = 2'h0;
   localparam logic [1:0] BOP_SET = 2'h1;
   // file address that carries the read side effect
   localparam logic [6:0] SECOND_IO_PORT_ADDR = 7'h06;
   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [11:0] CTRL_OFS   = 12'h000;
   localparam logic [11:0] ACC_OFS    = 12'h004;
   localparam logic [11:0] STATUS_OFS = 12'h008;
   localparam logic [11:0] INSTR_OFS  = 12'h00C;
   localparam int ST_C  = 0;
   localparam int ST_DC = 1;
   localparam int ST_Z  = 2;
   localparam int ST_FO = 3;
   localparam logic [7:0] ACC_RST = 8'h00;
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} bfd_phase_t;
   typedef struct packed {
      bfd_phase_t  ph;
      logic        run;
      logic [7:0]  acc;
      logic        c;
      logic        dc;
      logic        z;
      logic        foreign;
      logic [13:0] instr;
      logic        op_vld;
      logic        skip_pend;
      logic [6:0]  faddr;
      logic        frd;
      logic        fwr;
      logic [7:0]  fwdata;
      logic        port_clr;
      logic        take;
      logic        skip;
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } bfd_state_t;
endpackage : bfd_pkg

// ### dv/bfd_decoder_props.sv
// port assertions for the byte file op decoder
module bfd_decoder_props (
   input wire logic       CLK_I,
   input wire logic       RST_N_I,
   input wire logic       PSEL_I,
   input wire logic       PENABLE_I,
   input wire logic       PREADY_O,
   input wire logic       PSLVERR_O,
   input wire logic       INSTR_TAKE_O,
   input wire logic       SKIP_O,
   input wire logic [6:0] FILE_ADDR_O,
   input wire logic       FILE_RD_O,
   input wire logic       FILE_WR_O,
   input wire logic [7:0] FILE_WDATA_O,
   input wire logic       PORT_CHG_CLR_O
);
   timeunit 1ns;
   timeprecision 1ns;
   import bfd_pkg::*;
   // -----
   // one clock domain, so a single default
   // -----
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   property p_rd_after_take;
      FILE_RD_O |-> $past(INSTR_TAKE_O);
   endproperty
   a_rd_after_take: assert property (p_rd_after_take) else $error("file read without a taken word");
   property p_wr_after_rd;
      FILE_WR_O |-> $past(FILE_RD_O) && $stable(FILE_ADDR_O);
   endproperty
   a_wr_after_rd: assert property (p_wr_after_rd) else $error("file write not after its read");
   property p_port_clr;
      PORT_CHG_CLR_O == (FILE_RD_O && FILE_ADDR_O == SECOND_IO_PORT_ADDR);
   endproperty
   a_port_clr: assert property (p_port_clr) else $error("port change clear mismatch");
   property p_skip_src;
      SKIP_O |-> $past(FILE_RD_O);
   endproperty
   a_skip_src: assert property (p_skip_src) else $error("skip without file read");
   property p_skip_zero;
      SKIP_O && FILE_WR_O |-> FILE_WDATA_O == 8'h00;
   endproperty
   a_skip_zero: assert property (p_skip_zero) else $error("skip on nonzero result");
   property p_take_gap;
      INSTR_TAKE_O |=> !INSTR_TAKE_O [*3];
   endproperty
   a_take_gap: assert property (p_take_gap) else $error("words taken closer than four clocks");
   property p_apb_wait;
      PSEL_I && !PENABLE_I ##1 PSEL_I && PENABLE_I |-> !PREADY_O ##1 PREADY_O;
   endproperty
   a_apb_wait: assert property (p_apb_wait) else $error("ready not after one wait state");
   property p_err_ready;
      PSLVERR_O |-> PREADY_O;
   endproperty
   a_err_ready: assert property (p_err_ready) else $error("error without ready");
endmodule : bfd_decoder_props

bind bfd_decoder bfd_decoder_props i_props (.CLK_I, .RST_N_I, .PSEL_I, .PENABLE_I, .PREADY_O, .PSLVERR_O,
   .INSTR_TAKE_O, .SKIP_O, .FILE_ADDR_O, .FILE_RD_O, .FILE_WR_O, .FILE_WDATA_O, .PORT_CHG_CLR_O);

// ### dv/bfd_file_model.sv
// behavioural file register array on the far side of the decoder
module bfd_file_model (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic [6:0] addr_i,
   input  wire logic       rd_i,
   input  wire logic       wr_i,
   input  wire logic [7:0] wdata_i,
   output logic      [7:0] rdata_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [128];
   logic [7:0] idle_q;
   // data stand while the read strobe is high, as the decoder uses them in that cycle
   // otherwise a toggling value shows any stale use
   assign rdata_o = rd_i ? mem[addr_i] : idle_q;
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         idle_q <= 8'hA5;
      end else begin
         idle_q <= ~idle_q;
         if (wr_i) begin
            mem[addr_i] <= wdata_i;
         end
      end
   end
endmodule : bfd_file_model

// ### dv/testbench.sv
// self-checking bench for the byte file op decoder
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import bfd_pkg::*;
   logic        CLK_I, RST_N_I, PSEL_I, PENABLE_I, PWRITE_I, INSTR_VLD_I, PREADY_O, PSLVERR_O;
   logic        INSTR_TAKE_O, SKIP_O, FILE_RD_O, FILE_WR_O, PORT_CHG_CLR_O, perr;
   logic [11:0] PADDR_I;
   logic [31:0] PWDATA_I, PRDATA_O, rdat;
   logic [13:0] INSTR_I;
   logic [7:0]  FILE_RDATA_I, FILE_WDATA_O;
   logic [6:0]  FILE_ADDR_O;
   int          num_errors, checks_done, nskip, nclr;
   bfd_decoder i_bfd_decoder (.CLK_I, .RST_N_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I,
      .PRDATA_O, .PREADY_O, .PSLVERR_O, .INSTR_I, .INSTR_VLD_I, .INSTR_TAKE_O, .SKIP_O, .FILE_ADDR_O,
      .FILE_RD_O, .FILE_RDATA_I, .FILE_WR_O, .FILE_WDATA_O, .PORT_CHG_CLR_O);
   bfd_file_model i_bfd_file_model (.clk_i(CLK_I), .rst_n_i(RST_N_I), .addr_i(FILE_ADDR_O),
      .rd_i(FILE_RD_O), .wr_i(FILE_WR_O), .wdata_i(FILE_WDATA_O), .rdata_o(FILE_RDATA_I));
   // 40 ns clock
   initial begin
      CLK_I = 1'h0;
      forever #20 CLK_I = ~CLK_I;
   end
   // count pulses away from the edge so they are settled
   always @(negedge CLK_I) begin
      if (SKIP_O === 1'h1) nskip++;
      if (PORT_CHG_CLR_O === 1'h1) nclr++;
   end
   // -----
   // tasks
   // -----
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // one APB transfer; request held until the edge where ready is sampled
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge CLK_I);
      PSEL_I   <= 1'h1;
      PWRITE_I <= w;
      PADDR_I  <= a;
      PWDATA_I <= d;
      @(posedge CLK_I);
      PENABLE_I <= 1'h1;
      n = 0;
      // ready is looked at on each rising edge, before that edge's updates land
      do begin
         @(posedge CLK_I);
         n++;
      end while (PREADY_O !== 1'h1 && n < 16);
      if (PREADY_O !== 1'h1) num_errors++;
      rdat = PRDATA_O;
      perr = PSLVERR_O;
      PSEL_I    <= 1'h0;
      PENABLE_I <= 1'h0;
   endtask : apb
   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'h0, a, 32'h0);
      chk(rdat, exp);
   endtask : rchk
   // offer one word and hold it until taken, then let it finish
   task automatic ex(input logic [13:0] w);
      int n;
      @(posedge CLK_I);
      INSTR_I     <= w;
      INSTR_VLD_I <= 1'h1;
      n = 0;
      do begin
         @(negedge CLK_I);
         n++;
      end while (INSTR_TAKE_O !== 1'h1 && n < 16);
      if (INSTR_TAKE_O !== 1'h1) num_errors++;
      @(posedge CLK_I);
      INSTR_VLD_I <= 1'h0;
      repeat (4) @(posedge CLK_I);
   endtask : ex
   task automatic end_of_test();
      if (num_errors == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_of_test
   // watchdog well beyond the expected run of about 8 us
   initial begin
      #100000;
      num_errors++;
      end_of_test();
   end
   // -----
   // main sequence
   // -----
   initial begin
      {RST_N_I, PSEL_I, PENABLE_I, PWRITE_I, INSTR_VLD_I} = 5'h00;
      PADDR_I = 12'h000;
      PWDATA_I = 32'h0;
      INSTR_I = 14'h0000;
      i_bfd_file_model.mem[7'h20] = 8'h0F;
      i_bfd_file_model.mem[7'h21] = 8'h01;
      i_bfd_file_model.mem[7'h22] = 8'hFF;
      i_bfd_file_model.mem[7'h06] = 8'h5A;
      i_bfd_file_model.mem[7'h23] = 8'hF8;
      i_bfd_file_model.mem[7'h7F] = 8'h80;
      repeat (3) @(posedge CLK_I);
      RST_N_I <= 1'h1;
      rchk(ACC_OFS, 32'h0);
      rchk(STATUS_OFS, 32'h0);
      rchk(12'h010, 32'h0);
      chk(perr, 1'h1);
      apb(1'h1, CTRL_OFS, 32'h1);
      apb(1'h1, ACC_OFS, 32'hF0);
      ex(14'h0420);
      rchk(ACC_OFS, 32'hFF);
      rchk(STATUS_OFS, 32'h0);
      ex(14'h04A0);
      chk(i_bfd_file_model.mem[7'h20], 32'hFF);
      ex(14'h0BA1);
      ex(14'h0100);
      rchk(ACC_OFS, 32'hFF);
      chk(i_bfd_file_model.mem[7'h21], 32'h0);
      rchk(STATUS_OFS, 32'h0);
      ex(14'h0F22);
      ex(14'h0420);
      rchk(ACC_OFS, 32'h0);
      chk(i_bfd_file_model.mem[7'h22], 32'hFF);
      chk(nskip, 32'h2);
      ex(14'h0186);
      chk(nclr, 32'h1);
      chk(i_bfd_file_model.mem[7'h06], 32'h0);
      rchk(STATUS_OFS, 32'h4);
      apb(1'h1, STATUS_OFS, 32'h0);
      apb(1'h1, ACC_OFS, 32'h55);
      ex(14'h0106);
      rchk(ACC_OFS, 32'h0);
      rchk(STATUS_OFS, 32'h4);
      chk(nclr, 32'h1);
      apb(1'h1, STATUS_OFS, 32'h0);
      apb(1'h1, ACC_OFS, 32'h08);
      ex(14'h0723);
      rchk(ACC_OFS, 32'h0);
      rchk(STATUS_OFS, 32'h7);
      ex(14'h0AFF);
      chk(i_bfd_file_model.mem[7'h7F], 32'h81);
      rchk(STATUS_OFS, 32'h3);
      ex(14'h1521);
      chk(i_bfd_file_model.mem[7'h21], 32'h04);
      ex(14'h1121);
      chk(i_bfd_file_model.mem[7'h21], 32'h0);
      ex(14'h1821);
      rchk(STATUS_OFS, 32'hB);
      rchk(INSTR_OFS, 32'h1821);
      chk(i_bfd_file_model.mem[7'h21], 32'h0);
      apb(1'h1, STATUS_OFS, 32'h8);
      rchk(STATUS_OFS, 32'h0);
      rchk(CTRL_OFS, 32'h1);
      end_of_test();
   end
endmodule : testbench
